// File: cache_line_pkg.sv
`default_nettype none

package cache_line_pkg;

    // geometry and bus widths
    localparam int WAYS   = 4;
    localparam int WAY_W  = 2;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // line state encoding {valid, modified}
    localparam logic [1:0] LINE_INVALID  = 2'h0;
    localparam logic [1:0] LINE_VALID    = 2'h2;
    localparam logic [1:0] LINE_MODIFIED = 2'h3;

    // reset values
    localparam logic [WAY_W-1:0] RR_RESET = 2'h0;

    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_INVALIDATE,
        OP_PUSH_INVALIDATE,
        OP_PUSH_KEEP,
        OP_INVALIDATE_ALL
    } op_t;

    // addr is a word address
    typedef struct packed {
        op_t               op;
        logic              copyback;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cpu_req_t;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;

endpackage : cache_line_pkg

`default_nettype wire

// File: line_victim_select.sv
`timescale 1ns/1ps
`default_nettype none

module line_victim_select
    import cache_line_pkg::*;
#(
    parameter int N = WAYS
) (
    // per-way occupancy of the selected set
    input  wire logic [N-1:0]     occupied_i,
    input  wire logic [WAY_W-1:0] rr_i,
    // chosen way
    output logic [WAY_W-1:0]      way_o,
    output logic                  replace_o
);

    if (N != WAYS) begin : g_bad_n
        $error("line_victim_select: N must equal WAYS");
    end

    // lowest free way first, otherwise the rotating pointer
    always_comb begin
        way_o     = rr_i;
        replace_o = 1'b1;
        for (int w = N - 1; w >= 0; w--) begin
            if (!occupied_i[w]) begin
                way_o     = WAY_W'(w);
                replace_o = 1'b0;
            end
        end
    end

endmodule : line_victim_select

`default_nettype wire

// File: cache_line_state_control.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1: Read miss on an invalid line fills it, returns data, ends valid.
// RQ2: Copyback write miss on invalid/valid fills, merges, ends modified.
// RQ3: Write-through write miss writes memory only; line state unchanged.
// RQ4: Read miss replacing a valid line refills, returns data, stays valid.
// RQ5: Read hit returns cached data with no memory access or state change.
// RQ6: Copyback write hit updates only the cache and ends modified.
// RQ7: Write-through write hit on a valid line writes both, stays valid.
// RQ8: Write-through write hit on a modified line writes both, ends valid.
// RQ9: Read miss on modified victim buffers, fills, returns, then drains.
// RQ10: Copyback write miss, modified victim: buffer, fill, drain, modified.
// RQ11: Invalidate drops the line to invalid with no memory transfer.
// RQ12: Push writes back a modified line, then ends invalid or valid.
// RQ13: Invalidate or push on an invalid line keeps it invalid, no memory use.
// RQ14: Software leaves no modified line in a region it turns write-through.
// RQ15: Each line state is a valid bit and a modified bit.
// RQ16: Fills prefer an invalid way, else a pseudo round-robin victim of four.
// RQ17: A hit needs a tag match and a set valid bit.
module cache_line_state_control
    import cache_line_pkg::*;
#(
    parameter int SETS  = 128,
    parameter int WORDS = 4
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // processor request
    input  wire logic              req_valid_i,
    input  wire cpu_req_t          req_i,
    output logic                   req_ready_o,
    // processor response
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    // memory side
    output logic                   mem_valid_o,
    output mem_req_t               mem_req_o,
    input  wire logic              mem_ack_i,
    input  wire logic [DATA_W-1:0] mem_rdata_i
);

    localparam int OFF_W = $clog2(WORDS);
    localparam int IDX_W = $clog2(SETS);
    localparam int TAG_W = ADDR_W - IDX_W - OFF_W;

    if (WORDS < 2 || (1 << OFF_W) != WORDS || SETS < 2 ||
        (1 << IDX_W) != SETS) begin : g_bad_geometry
        $error("cache_line_state_control: SETS/WORDS not powers of two");
    end

    typedef enum {S_IDLE, S_LOOK, S_FILL, S_WT, S_DRAIN} state_t;

    // storage
    logic [TAG_W-1:0]  tag_mem  [SETS][WAYS];
    logic [DATA_W-1:0] data_mem [SETS][WAYS][WORDS];
    logic [WAYS-1:0]   v_mem    [SETS];
    logic [WAYS-1:0]   m_mem    [SETS];
    logic [DATA_W-1:0] push_buf [WORDS];

    // control state
    state_t            state, next_state;
    cpu_req_t          cur, next_cur;
    logic [WAY_W-1:0]  way, next_way;
    logic [OFF_W-1:0]  cnt, next_cnt;
    logic [WAY_W-1:0]  rr, next_rr;
    logic              drain_pend, next_drain_pend;
    logic              push_rsp, next_push_rsp;
    logic [ADDR_W-1:0] push_base, next_push_base;
    logic              rsp_valid, next_rsp_valid;
    logic [DATA_W-1:0] rsp_rdata, next_rsp_rdata;

    // storage write controls
    logic              data_we;
    logic [WAY_W-1:0]  data_way;
    logic [OFF_W-1:0]  data_word;
    logic [DATA_W-1:0] data_wdata;
    logic              st_we;
    logic [WAY_W-1:0]  st_way;
    logic [1:0]        st_val;
    logic              tag_we;
    logic              buf_load;
    logic              inval_all;

    // address fields of the held request
    logic [OFF_W-1:0]  off;
    logic [IDX_W-1:0]  idx;
    logic [TAG_W-1:0]  tag;
    logic [WAYS-1:0]   hit_vec;
    logic              hit;
    logic [WAY_W-1:0]  hit_way;
    logic [WAY_W-1:0]  victim;
    logic              replace;
    logic [1:0]        hit_st;
    logic              last;

    assign off  = cur.addr[OFF_W-1:0];
    assign idx  = cur.addr[OFF_W+IDX_W-1:OFF_W];
    assign tag  = cur.addr[ADDR_W-1:OFF_W+IDX_W];
    assign last = (cnt == OFF_W'(WORDS - 1));

    always_comb begin
        hit_way = '0;
        for (int w = 0; w < WAYS; w++) begin
            hit_vec[w] = v_mem[idx][w] && (tag_mem[idx][w] == tag); // [RQ17]
            if (hit_vec[w]) begin
                hit_way = WAY_W'(w);
            end
        end
        hit    = |hit_vec;
        hit_st = {v_mem[idx][hit_way], m_mem[idx][hit_way]}; // [RQ15]
    end

    line_victim_select #(
        .N(WAYS)
    ) u_victim (
        .occupied_i(v_mem[idx]),
        .rr_i      (rr),
        .way_o     (victim),
        .replace_o (replace)
    );

    always_comb begin
        next_state      = state;
        next_cur        = cur;
        next_way        = way;
        next_cnt        = cnt;
        next_rr         = rr;
        next_drain_pend = drain_pend;
        next_push_rsp   = push_rsp;
        next_push_base  = push_base;
        next_rsp_valid  = 1'b0;
        next_rsp_rdata  = rsp_rdata;
        data_we         = 1'b0;
        data_way        = way;
        data_word       = cnt;
        data_wdata      = cur.wdata;
        st_we           = 1'b0;
        st_way          = way;
        st_val          = LINE_INVALID;
        tag_we          = 1'b0;
        buf_load        = 1'b0;
        inval_all       = 1'b0;
        req_ready_o     = 1'b0;
        mem_valid_o     = 1'b0;
        mem_req_o       = '0;
        case (state)
            S_IDLE: begin
                req_ready_o = 1'b1;
                if (req_valid_i) begin
                    next_cur   = req_i;
                    next_state = S_LOOK;
                end
            end
            S_LOOK: begin
                next_cnt        = '0;
                next_drain_pend = 1'b0;
                next_push_rsp   = 1'b0;
                case (cur.op)
                    OP_READ, OP_WRITE: begin
                        if (cur.op == OP_WRITE && !cur.copyback) begin
                            if (hit) begin
                                data_we   = 1'b1; // [RQ7] [RQ8]
                                data_way  = hit_way;
                                data_word = off;
                                st_we     = 1'b1;
                                st_way    = hit_way;
                                st_val    = LINE_VALID; // [RQ8]
                            end
                            next_state = S_WT; // [RQ3]
                        end else if (hit) begin
                            if (cur.op == OP_READ) begin // [RQ5]
                                next_rsp_rdata = data_mem[idx][hit_way][off];
                            end else begin
                                data_we   = 1'b1; // [RQ6]
                                data_way  = hit_way;
                                data_word = off;
                                st_we     = 1'b1;
                                st_way    = hit_way;
                                st_val    = LINE_MODIFIED; // [RQ6]
                            end
                            next_rsp_valid = 1'b1;
                            next_state     = S_IDLE;
                        end else begin
                            next_way = victim; // [RQ16]
                            if (replace) begin
                                next_rr = rr + WAY_W'(1); // [RQ16]
                            end
                            if (m_mem[idx][victim] && v_mem[idx][victim]) begin
                                buf_load        = 1'b1; // [RQ9] [RQ10]
                                next_drain_pend = 1'b1;
                                next_push_base  = {tag_mem[idx][victim], idx,
                                                   OFF_W'(0)};
                            end
                            st_we      = 1'b1;
                            st_way     = victim;
                            st_val     = LINE_INVALID;
                            next_state = S_FILL; // [RQ1] [RQ2] [RQ4]
                        end
                    end
                    OP_INVALIDATE: begin
                        if (hit) begin
                            st_we  = 1'b1; // [RQ11]
                            st_way = hit_way;
                            st_val = LINE_INVALID;
                        end
                        next_rsp_valid = 1'b1; // [RQ13]
                        next_state     = S_IDLE;
                    end
                    OP_PUSH_INVALIDATE, OP_PUSH_KEEP: begin
                        if (hit) begin
                            st_we  = 1'b1;
                            st_way = hit_way;
                            st_val = (cur.op == OP_PUSH_KEEP) ? LINE_VALID
                                                              : LINE_INVALID;
                        end
                        if (hit && hit_st == LINE_MODIFIED) begin
                            next_way       = hit_way;
                            buf_load       = 1'b1; // [RQ12]
                            next_push_rsp  = 1'b1;
                            next_push_base = {tag, idx, OFF_W'(0)};
                            next_state     = S_DRAIN;
                        end else begin
                            next_rsp_valid = 1'b1; // [RQ13]
                            next_state     = S_IDLE;
                        end
                    end
                    OP_INVALIDATE_ALL: begin
                        inval_all      = 1'b1;
                        next_rsp_valid = 1'b1;
                        next_state     = S_IDLE;
                    end
                    default: begin
                        next_rsp_valid = 1'b1;
                        next_state     = S_IDLE;
                    end
                endcase
            end
            S_FILL: begin
                mem_valid_o    = 1'b1;
                mem_req_o.addr = {tag, idx, cnt};
                if (mem_ack_i) begin
                    data_we    = 1'b1;
                    data_wdata = mem_rdata_i;
                    if (cur.op == OP_WRITE && cnt == off) begin
                        data_wdata = cur.wdata; // [RQ2] [RQ10]
                    end
                    if (cur.op == OP_READ && cnt == off) begin
                        next_rsp_rdata = mem_rdata_i; // [RQ1] [RQ4]
                    end
                    next_cnt = cnt + OFF_W'(1);
                    if (last) begin
                        tag_we         = 1'b1;
                        st_we          = 1'b1;
                        st_val         = (cur.op == OP_WRITE) ? LINE_MODIFIED
                                                              : LINE_VALID;
                        next_rsp_valid = 1'b1; // [RQ9]
                        next_state     = drain_pend ? S_DRAIN : S_IDLE;
                    end
                end
            end
            S_WT: begin
                mem_valid_o     = 1'b1; // [RQ3] [RQ7]
                mem_req_o.we    = 1'b1;
                mem_req_o.addr  = cur.addr;
                mem_req_o.wdata = cur.wdata;
                if (mem_ack_i) begin
                    next_rsp_valid = 1'b1;
                    next_state     = S_IDLE;
                end
            end
            S_DRAIN: begin
                mem_valid_o     = 1'b1; // [RQ9] [RQ10] [RQ12]
                mem_req_o.we    = 1'b1;
                mem_req_o.addr  = push_base | ADDR_W'(cnt);
                mem_req_o.wdata = push_buf[cnt];
                if (mem_ack_i) begin
                    next_cnt = cnt + OFF_W'(1);
                    if (last) begin
                        next_rsp_valid = push_rsp;
                        next_state     = S_IDLE;
                    end
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= S_IDLE;
            cur        <= '0;
            way        <= '0;
            cnt        <= '0;
            rr         <= RR_RESET;
            drain_pend <= 1'b0;
            push_rsp   <= 1'b0;
            push_base  <= '0;
            rsp_valid  <= 1'b0;
            rsp_rdata  <= '0;
        end else begin
            state      <= next_state;
            cur        <= next_cur;
            way        <= next_way;
            cnt        <= next_cnt;
            rr         <= next_rr;
            drain_pend <= next_drain_pend;
            push_rsp   <= next_push_rsp;
            push_base  <= next_push_base;
            rsp_valid  <= next_rsp_valid;
            rsp_rdata  <= next_rsp_rdata;
        end
    end

    // line state bits, cleared at reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int s = 0; s < SETS; s++) begin
                v_mem[s] <= '0;
                m_mem[s] <= '0;
            end
        end else if (inval_all) begin
            for (int s = 0; s < SETS; s++) begin
                v_mem[s] <= '0;
                m_mem[s] <= '0;
            end
        end else if (st_we) begin
            v_mem[idx][st_way] <= st_val[1]; // [RQ15]
            m_mem[idx][st_way] <= st_val[0];
        end
    end

    // tags, line data and the push buffer
    always_ff @(posedge clk_i) begin
        if (tag_we) begin
            tag_mem[idx][way] <= tag;
        end
        if (data_we) begin
            data_mem[idx][data_way][data_word] <= data_wdata;
        end
        if (buf_load) begin
            for (int k = 0; k < WORDS; k++) begin
                push_buf[k] <= data_mem[idx][next_way][k];
            end
        end
    end

    assign rsp_valid_o = rsp_valid;
    assign rsp_rdata_o = rsp_rdata;

endmodule : cache_line_state_control

`default_nettype wire

// File: cache_line_state_control_sva.sv
`timescale 1ns/1ps
`default_nettype none

module cache_line_state_control_sva
    import cache_line_pkg::*;
#(
    parameter int SETS  = 128,
    parameter int WORDS = 4
) (
    // clock and reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    // processor side
    input wire logic              req_valid_i,
    input wire cpu_req_t          req_i,
    input wire logic              req_ready_o,
    input wire logic              rsp_valid_o,
    input wire logic [DATA_W-1:0] rsp_rdata_o,
    // memory side
    input wire logic              mem_valid_o,
    input wire mem_req_t          mem_req_o,
    input wire logic              mem_ack_i,
    input wire logic [DATA_W-1:0] mem_rdata_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence fill_beat;
        mem_valid_o && mem_ack_i && !mem_req_o.we;
    endsequence
    sequence fill_last;
        fill_beat ##0 ((mem_req_o.addr & (WORDS - 1)) == WORDS - 1);
    endsequence
    sequence fill_mid;
        fill_beat ##0 ((mem_req_o.addr & (WORDS - 1)) != WORDS - 1);
    endsequence
    sequence take_wt;
        req_valid_i && req_ready_o && req_i.op == OP_WRITE
            && !req_i.copyback;
    endsequence
    sequence take_inval;
        req_valid_i && req_ready_o
            && (req_i.op == OP_INVALIDATE || req_i.op == OP_INVALIDATE_ALL);
    endsequence

    a_reset_idle: assert property ($fell(rst_i) |-> req_ready_o
        && !rsp_valid_o && !mem_valid_o && rsp_rdata_o == '0)
        else $error("outputs not idle after reset");
    a_taken_busy: assert property (req_valid_i && req_ready_o
        |=> !req_ready_o) else $error("ready stayed high after take");
    a_rsp_single: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    a_rsp_caused: assert property (rsp_valid_o
        |-> !$past(req_ready_o))
        else $error("response without a busy cycle");
    a_idle_no_mem: assert property (req_ready_o |-> !mem_valid_o)
        else $error("memory request while idle");
    a_mem_held: assert property (mem_valid_o && !mem_ack_i
        |=> mem_valid_o && $stable(mem_req_o))
        else $error("memory request changed before ack");
    a_fill_aligned: assert property ($rose(mem_valid_o)
        && !mem_req_o.we |-> (mem_req_o.addr & (WORDS - 1)) == 0)
        else $error("fill not starting at word zero");
    a_fill_next: assert property (fill_mid |=> mem_valid_o
        && !mem_req_o.we && mem_req_o.addr == $past(mem_req_o.addr) + 1)
        else $error("fill word order broken");
    a_fill_done: assert property (fill_last |=> rsp_valid_o)
        else $error("no response after last fill word");
    a_wt_store: assert property (take_wt |=> ##1 (mem_valid_o
        && mem_req_o.we && mem_req_o.addr == $past(req_i.addr, 2)
        && mem_req_o.wdata == $past(req_i.wdata, 2)))
        else $error("write-through store missing or wrong");
    a_inval_quiet: assert property (take_inval |=> !mem_valid_o
        ##1 (rsp_valid_o && !mem_valid_o))
        else $error("invalidate touched memory or never answered");
endmodule : cache_line_state_control_sva

bind cache_line_state_control cache_line_state_control_sva #(
    .SETS (SETS),
    .WORDS(WORDS)
) u_sva (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .req_valid_i(req_valid_i),
    .req_i      (req_i),
    .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o),
    .mem_valid_o(mem_valid_o),
    .mem_req_o  (mem_req_o),
    .mem_ack_i  (mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
);

`default_nettype wire

// File: cache_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module cache_mem_model
    import cache_line_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // request from the cache
    input  wire logic              mem_valid_i,
    input  wire mem_req_t          mem_req_i,
    input  wire logic [1:0]        slow_i,
    // answer
    output logic                   mem_ack_o,
    output logic [DATA_W-1:0]      mem_rdata_o
);
    logic [DATA_W-1:0] store [logic [ADDR_W-1:0]];
    int                wait_left;

    // one process owns both outputs; the data bus churns between words
    initial begin
        mem_ack_o   = 1'b0;
        mem_rdata_o = 32'h0;
        wait_left   = 0;
        forever begin
            @(posedge clk_i);
            #1;
            mem_ack_o   = 1'b0;
            mem_rdata_o = ~mem_rdata_o;
            if (rst_i) begin
                wait_left = 0;
            end else if (mem_valid_i) begin
                if (wait_left > 0) begin
                    wait_left--;
                end else begin
                    mem_ack_o = 1'b1;
                    if (mem_req_i.we) begin
                        store[mem_req_i.addr] = mem_req_i.wdata;
                    end else if (store.exists(mem_req_i.addr)) begin
                        mem_rdata_o = store[mem_req_i.addr];
                    end else begin
                        mem_rdata_o = mem_req_i.addr ^ 32'hc3a5_0f1e;
                    end
                    wait_left = $urandom_range(slow_i, 0);
                end
            end
        end
    end
endmodule : cache_mem_model

`default_nettype wire

// File: cache_line_state_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cache_line_state_control_tb;
    import cache_line_pkg::*;

    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              req_valid_i = 1'b0;
    cpu_req_t          req_i = '0;
    logic              req_ready_o;
    logic              rsp_valid_o;
    logic [DATA_W-1:0] rsp_rdata_o;
    logic              mem_valid_o;
    mem_req_t          mem_req_o;
    logic              mem_ack_i;
    logic [DATA_W-1:0] mem_rdata_i;
    logic [1:0]        slow = 2'h0;
    logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] got;
    logic [ADDR_W-1:0] a;
    int                err_total, checks_done, rd_n, wr_n, wr_rsp;

    always #50 clk_i = ~clk_i;

    cache_line_state_control dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
        .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i)
    );
    cache_mem_model mem_u (
        .clk_i(clk_i), .rst_i(rst_i), .mem_valid_i(mem_valid_o),
        .mem_req_i(mem_req_o), .slow_i(slow),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i)
    );

    always @(posedge clk_i) begin
        if (mem_valid_o && mem_ack_i) begin
            if (mem_req_o.we) wr_n++;
            else rd_n++;
        end
    end

    function automatic logic [ADDR_W-1:0] ad(input int t, i, o);
        return ADDR_W'((t << 9) | (i << 2) | o);
    endfunction : ad

    function automatic logic [DATA_W-1:0] exp_word(
        input logic [ADDR_W-1:0] x);
        return ref_mem.exists(x) ? ref_mem[x] : x ^ 32'hc3a5_0f1e;
    endfunction : exp_word

    task automatic give_verdict();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(inout int n);
        @(posedge clk_i);
        #1;
        if (++n > 400) begin
            err_total++;
            give_verdict();
        end
    endtask : tick

    task automatic do_req(input op_t op, input logic cb,
                          input logic [ADDR_W-1:0] x,
                          input logic [DATA_W-1:0] d,
                          input int nrd, input int nwr);
        int n, rd0, wr0;
        n = 0;
        while (req_ready_o !== 1'b1) tick(n);
        rd0 = rd_n;
        wr0 = wr_n;
        req_i = '{op: op, copyback: cb, addr: x, wdata: d};
        req_valid_i = 1'b1;
        tick(n);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1) tick(n);
        got = rsp_rdata_o;
        wr_rsp = wr_n - wr0;
        while (req_ready_o !== 1'b1) tick(n);
        if (op == OP_WRITE) ref_mem[x] = d;
        if (op == OP_READ) check(got, exp_word(x));
        if (nrd >= 0) check(rd_n - rd0, nrd);
        if (nwr >= 0) check(wr_n - wr0, nwr);
    endtask : do_req

    initial begin
        void'($urandom(32'h8c65));
        repeat (16) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        check({rsp_rdata_o[30:0], req_ready_o}, 32'h1);
        a = ad(1, 5, 2);
        do_req(OP_READ, 1, a, 0, 4, 0);
        do_req(OP_READ, 1, a, 0, 0, 0);
        do_req(OP_WRITE, 1, a, 32'h1111_0001, 0, 0);
        do_req(OP_WRITE, 1, a, 32'h1111_0002, 0, 0);
        do_req(OP_READ, 1, a, 0, 0, 0);
        do_req(OP_WRITE, 0, a, 32'h1111_0003, 0, 1);
        do_req(OP_PUSH_KEEP, 1, a, 0, 0, 0);
        do_req(OP_WRITE, 0, a, 32'h1111_0004, 0, 1);
        do_req(OP_PUSH_INVALIDATE, 1, a, 0, 0, 0);
        do_req(OP_READ, 1, a, 0, 4, 0);
        do_req(OP_WRITE, 1, a, 32'h1111_0005, 0, 0);
        do_req(OP_PUSH_INVALIDATE, 1, a, 0, 0, 4);
        do_req(OP_READ, 1, a, 0, 4, 0);
        do_req(OP_WRITE, 1, a, 32'h1111_0006, 0, 0);
        do_req(OP_PUSH_KEEP, 1, a, 0, 0, 4);
        do_req(OP_READ, 1, a, 0, 0, 0);
        do_req(OP_WRITE, 1, a, 32'h1111_0007, 0, 0);
        do_req(OP_INVALIDATE, 1, a, 0, 0, 0);
        ref_mem[a] = 32'h1111_0006;
        do_req(OP_READ, 1, a, 0, 4, 0);
        do_req(OP_INVALIDATE, 1, a, 0, 0, 0);
        for (int op = 2; op < 5; op++) begin
            do_req(op_t'(op), 1, a, 0, 0, 0);
        end
        do_req(OP_WRITE, 0, ad(2, 6, 1), 32'h2222_0001, 0, 1);
        do_req(OP_READ, 0, ad(2, 6, 1), 0, 4, 0);
        do_req(OP_WRITE, 1, ad(3, 7, 0), 32'h3333_0001, 4, 0);
        do_req(OP_READ, 1, ad(3, 7, 0), 0, 0, 0);
        for (int t = 1; t < 5; t++) begin
            do_req(OP_WRITE, 1, ad(t, 9, t - 1), 32'h4444_0000 + t,
                   4, 0);
        end
        do_req(OP_READ, 1, ad(5, 9, 3), 0, 4, 4);
        check(wr_rsp, 0);
        do_req(OP_WRITE, 1, ad(6, 9, 2), 32'h4444_0006, 4, 4);
        do_req(OP_READ, 1, ad(4, 9, 3), 0, 0, 0);
        do_req(OP_READ, 1, ad(1, 9, 0), 0, 4, 4);
        do_req(OP_READ, 1, ad(3, 9, 2), 0, 4, 4);
        do_req(OP_READ, 1, ad(6, 9, 2), 0, 0, 0);
        do_req(OP_INVALIDATE_ALL, 1, a, 0, 0, 0);
        ref_mem.delete(ad(6, 9, 2));
        ref_mem.delete(ad(3, 7, 0));
        do_req(OP_READ, 1, ad(6, 9, 2), 0, 4, 0);
        do_req(OP_READ, 1, ad(3, 7, 0), 0, 4, 0);
        // region mode is fixed by one tag bit, so no mode switch
        repeat (80) begin
            slow = 2'($urandom_range(3, 0));
            a = ad($urandom_range(7, 0), $urandom_range(3, 0),
                   $urandom_range(3, 0));
            do_req(op_t'($urandom_range(4, 0) & 3'h5 ? 1 : 0), a[9], a,
                   $urandom, -1, -1);
            if ($urandom_range(3, 0) == 0) begin
                do_req(OP_PUSH_KEEP, a[9], a, 0, -1, -1);
            end
        end
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        a = ad(1, 5, 2);
        do_req(OP_READ, 1, a, 0, 4, 0);
        give_verdict();
    end
endmodule : cache_line_state_control_tb

`default_nettype wire
